// *** i2c_params.svh ***
// named constants of the two-wire bus controller
// assumes one operating clock and counts every time in its periods
`ifndef I2C_PARAMS_SVH
`define I2C_PARAMS_SVH

// operating clock period in ns
`define I2C_OPCLK_PERIOD_NS   10
// own slave address after reset
`define I2C_OWN_ADDR_RST      7'h40
// divider lower limit
`define I2C_N_MIN             8'h01
// multiples of (1+N) clock periods
`define I2C_MULT_HOLD         12'h002
`define I2C_MULT_START        12'h004
`define I2C_MULT_HI_SM        12'h004
`define I2C_MULT_HI_FM        12'h002
`define I2C_MULT_FREE         12'h004
// bit slots within one byte frame
`define I2C_LAST_IDX          4'h7
`define I2C_ACK_IDX           4'h8
// slot before bit 0, left by the scl fall that ends a start
`define I2C_PRE_IDX           4'hf
// slave sda hold after scl fall, in clock periods
`define I2C_SLV_HOLD_PERIODS  4
`define I2C_SYNC_STAGES       2
`define I2C_SLV_DLY_CYC       (`I2C_SLV_HOLD_PERIODS - `I2C_SYNC_STAGES)
`define I2C_SLV_DLY_W         3

`endif

// *** i2c_pkg.sv ***
// types shared by the two-wire bus controller
// assumes nothing beyond the constants header
package i2c_pkg;

	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ  = 2'h2,
		CMD_STOP  = 2'h3
	} cmd_t;

	typedef enum logic [3:0] {
		M_IDLE   = 4'h0,
		M_START  = 4'h1,
		M_HOLD   = 4'h3,
		M_SETUP  = 4'h2,
		M_HIGH   = 4'h6,
		M_WAIT   = 4'h7,
		M_STOP_A = 4'h5,
		M_STOP_B = 4'h4,
		M_STOP_C = 4'hc,
		M_FREE   = 4'hd,
		M_RS_A   = 4'hf,
		M_RS_B   = 4'he,
		M_RS_C   = 4'ha
	} mst_state_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_ADDR = 2'h1,
		S_RX   = 2'h3,
		S_TX   = 2'h2
	} slv_state_t;

	typedef enum logic [2:0] {
		ROLE_IDLE = 3'h0,
		ROLE_MTX  = 3'h1,
		ROLE_MRX  = 3'h3,
		ROLE_SRX  = 3'h2,
		ROLE_STX  = 3'h6
	} role_t;

endpackage

// *** i2c_input_sync.sv ***
// two-stage synchroniser for the scl and sda inputs
// assumes lines idle high
`timescale 1ns/10ps
`default_nettype none
module i2c_input_sync
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// lines
	input  wire logic [1:0] din,
	output logic      [1:0] dout
);
	logic [1:0] meta_q;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			meta_q <= 2'h3;
			dout   <= 2'h3;
		end
		else
		begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** i2c_phase_timer.sv ***
// down counter timing one bus phase
// assumes a load of len-1 gives a phase of len cycles
`timescale 1ns/10ps
`default_nettype none
module i2c_phase_timer
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// control
	input  wire logic        load,
	input  wire logic [11:0] loadVal,
	output logic             done
);
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;

	always_comb
	begin
		cnt_d = cnt_q;
		if (load)
			cnt_d = loadVal;
		else if (cnt_q != 12'h000)
			cnt_d = cnt_q - 12'h001;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			cnt_q <= 12'h000;
		else
			cnt_q <= cnt_d;
	end

	assign done = (cnt_q == 12'h000);
endmodule
`default_nettype wire

// *** i2c_master_slave_controller.sv ***
// two-wire bus controller, master or addressed slave
// assumes static mode and divider during a transfer, pull-ups on the wires
`timescale 1ns/10ps
`default_nettype none
`include "i2c_params.svh"
module i2c_master_slave_controller
	import i2c_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// configuration
	input  wire logic       masterMode,
	input  wire logic       fastMode,
	input  wire logic [7:0] divN,
	input  wire logic [6:0] ownAddrIn,
	input  wire logic       ownAddrWr,
	// master commands
	input  wire logic       cmdValid,
	input  wire cmd_t       cmdCode,
	input  wire logic [7:0] cmdData,
	output logic            cmdReady,
	output logic            rspValid,
	output logic      [7:0] rspData,
	output logic            rspAck,
	// slave data
	input  wire logic [7:0] slvTxData,
	output logic            slvTxTake,
	output logic            slvAddrHit,
	output logic            slvRxValid,
	output logic      [7:0] slvRxData,
	output logic            slvStop,
	// status
	output var role_t       role,
	// bus pins
	input  wire logic       sclIn,
	output logic            sclOut,
	output logic            sclOe,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe
);
	localparam int SlvDly = `I2C_SLV_DLY_CYC;

	function automatic logic [11:0] phaseLen(input logic [11:0] mult,
		input logic [7:0] n);
		logic [11:0] q;
		q = {4'h0, n} + 12'h001;
		phaseLen = 12'(mult * q) - 12'h001;
	endfunction

	logic [1:0]  syncOut;
	logic        sclS, sdaS, sclP_q, sdaP_q;
	logic        sclRise, sclFall, startDet, stopDet;
	logic [7:0]  nEff;
	logic [11:0] lenHold, lenStart, lenHi;
	logic        tmrLoad, tmrDone;
	logic [11:0] tmrVal;

	i2c_input_sync uSync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.din     ({sclIn, sdaIn}),
		.dout    (syncOut)
	);
	assign sclS = syncOut[1];
	assign sdaS = syncOut[0];
	assign sclRise  = sclS && !sclP_q;
	assign sclFall  = !sclS && sclP_q;
	// start and stop seen with scl high
	assign startDet = sclS && sclP_q && sdaP_q && !sdaS;
	assign stopDet  = sclS && sclP_q && !sdaP_q && sdaS;

	assign nEff = (divN < `I2C_N_MIN) ? `I2C_N_MIN : divN;
	// phases in multiples of (1+N) clocks
	assign lenHold  = phaseLen(`I2C_MULT_HOLD, nEff);
	assign lenStart = phaseLen(`I2C_MULT_START, nEff);
	assign lenHi = phaseLen(fastMode ? `I2C_MULT_HI_FM : `I2C_MULT_HI_SM,
		nEff);

	i2c_phase_timer uTimer (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (tmrLoad),
		.loadVal (tmrVal),
		.done    (tmrDone)
	);

	// master engine
	mst_state_t mState_q, mState_d;
	logic       mSclLow_q, mSclLow_d, mSdaLow_q, mSdaLow_d;
	logic [7:0] shReg_q, shReg_d;
	logic [3:0] mBit_q, mBit_d;
	logic       mWrite_q, mWrite_d, nackLast_q, nackLast_d;
	logic       mAddr_q, mAddr_d;
	logic       cmdReady_d, rspValid_d, rspAck_d, take, bitLow;
	logic [7:0] rspData_d;

	always_comb
	begin
		mState_d   = mState_q;
		mSclLow_d  = mSclLow_q;
		mSdaLow_d  = mSdaLow_q;
		shReg_d    = shReg_q;
		mBit_d     = mBit_q;
		mWrite_d   = mWrite_q;
		nackLast_d = nackLast_q;
		mAddr_d    = mAddr_q;
		rspValid_d = 1'b0;
		rspData_d  = rspData;
		rspAck_d   = rspAck;
		tmrLoad    = 1'b0;
		tmrVal     = lenHold;
		take       = cmdValid && cmdReady;
		// value for the coming bit slot
		if (mWrite_q)
			bitLow = (mBit_q == `I2C_ACK_IDX) ? 1'b0 : !shReg_q[7];
		else
			bitLow = (mBit_q == `I2C_ACK_IDX) ? !nackLast_q : 1'b0;
		case (mState_q)
			M_IDLE:
				if (take && cmdCode == CMD_START)
				begin
					mState_d  = M_START;
					mAddr_d   = 1'b1;
					mSdaLow_d = 1'b1;
					tmrLoad   = 1'b1;
					tmrVal    = lenStart;
					shReg_d   = cmdData;
					mWrite_d  = 1'b1;
					mBit_d    = 4'h0;
				end
			M_START:
				// scl stays high after start edge
				if (tmrDone)
				begin
					mState_d  = M_HOLD;
					mSclLow_d = 1'b1;
					tmrLoad   = 1'b1;
				end
			M_HOLD:
				// hold after fall, then present bit
				if (tmrDone)
				begin
					mState_d  = M_SETUP;
					mSdaLow_d = bitLow;
					tmrLoad   = 1'b1;
				end
			M_SETUP:
				if (tmrDone)
				begin
					mState_d  = M_HIGH;
					mSclLow_d = 1'b0;
					tmrLoad   = 1'b1;
					tmrVal    = lenHi;
				end
			M_HIGH:
				if (tmrDone)
				begin
					mSclLow_d = 1'b1;
					tmrLoad   = 1'b1;
					if (mBit_q == `I2C_ACK_IDX)
					begin
						// low at ack slot means acknowledged
						rspValid_d = 1'b1;
						rspAck_d   = !sdaS;
						rspData_d  = shReg_q;
						mBit_d     = 4'h0;
						mState_d   = M_WAIT;
						mAddr_d    = 1'b0;
						if (mAddr_q && !sdaS)
							mWrite_d = !shReg_q[0];
					end
					else
					begin
						shReg_d  = {shReg_q[6:0], sdaS};
						mBit_d   = mBit_q + 4'h1;
						mState_d = M_HOLD;
					end
				end
			M_WAIT:
				// next byte, stop or repeated start
				if (take)
				begin
					tmrLoad = 1'b1;
					case (cmdCode)
						CMD_START:
						begin
							mState_d = M_RS_A;
							mAddr_d  = 1'b1;
							shReg_d  = cmdData;
							mWrite_d = 1'b1;
						end
						CMD_WRITE:
						begin
							mState_d = M_HOLD;
							shReg_d  = cmdData;
							mWrite_d = 1'b1;
						end
						CMD_READ:
						begin
							mState_d   = M_HOLD;
							mWrite_d   = 1'b0;
							nackLast_d = cmdData[0];
						end
						default:
							mState_d = M_STOP_A;
					endcase
				end
			M_STOP_A:
				if (tmrDone)
				begin
					mState_d  = M_STOP_B;
					mSdaLow_d = 1'b1;
					tmrLoad   = 1'b1;
				end
			M_STOP_B:
				if (tmrDone)
				begin
					mState_d  = M_STOP_C;
					mSclLow_d = 1'b0;
					tmrLoad   = 1'b1;
				end
			M_STOP_C:
				if (tmrDone)
				begin
					mState_d  = M_FREE;
					mSdaLow_d = 1'b0;
					tmrLoad   = 1'b1;
					tmrVal    = lenStart;
				end
			M_FREE:
				// bus free before any new start
				if (tmrDone)
					mState_d = M_IDLE;
			M_RS_A:
				if (tmrDone)
				begin
					mState_d  = M_RS_B;
					mSdaLow_d = 1'b0;
					tmrLoad   = 1'b1;
				end
			M_RS_B:
				if (tmrDone)
				begin
					mState_d  = M_RS_C;
					mSclLow_d = 1'b0;
					tmrLoad   = 1'b1;
				end
			M_RS_C:
				if (tmrDone)
				begin
					mState_d  = M_START;
					mSdaLow_d = 1'b1;
					mBit_d    = 4'h0;
					tmrLoad   = 1'b1;
					tmrVal    = lenStart;
				end
			default:
				mState_d = M_IDLE;
		endcase
		if (!masterMode)
		begin
			mState_d  = M_IDLE;
			mSclLow_d = 1'b0;
			mSdaLow_d = 1'b0;
		end
		cmdReady_d = masterMode
			&& (mState_d == M_IDLE || mState_d == M_WAIT);
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			mState_q   <= M_IDLE;
			mSclLow_q  <= 1'b0;
			mSdaLow_q  <= 1'b0;
			shReg_q    <= 8'h00;
			mBit_q     <= 4'h0;
			mWrite_q   <= 1'b1;
			nackLast_q <= 1'b0;
			mAddr_q    <= 1'b0;
			cmdReady   <= 1'b0;
			rspValid   <= 1'b0;
			rspData    <= 8'h00;
			rspAck     <= 1'b0;
		end
		else
		begin
			mState_q   <= mState_d;
			mSclLow_q  <= mSclLow_d;
			mSdaLow_q  <= mSdaLow_d;
			shReg_q    <= shReg_d;
			mBit_q     <= mBit_d;
			mWrite_q   <= mWrite_d;
			nackLast_q <= nackLast_d;
			mAddr_q    <= mAddr_d;
			cmdReady   <= cmdReady_d;
			rspValid   <= rspValid_d;
			rspData    <= rspData_d;
			rspAck     <= rspAck_d;
		end
	end

	// slave engine
	slv_state_t                 sState_q, sState_d;
	logic [3:0]                 sBit_q, sBit_d;
	logic [7:0]                 sShift_q, sShift_d, slvRxData_d;
	logic [`I2C_SLV_DLY_W-1:0]  sDly_q, sDly_d;
	logic                       sSdaLow_q, sSdaLow_d, sPend_q, sPend_d;
	logic                       sRead_q, sRead_d, sNack_q, sNack_d;
	logic [6:0]                 ownAddr_q, ownAddr_d;
	logic                       locked_q, locked_d;
	logic                       slvTxTake_d, slvAddrHit_d;
	logic                       slvRxValid_d, slvStop_d;

	always_comb
	begin
		sState_d     = sState_q;
		sBit_d       = sBit_q;
		sShift_d     = sShift_q;
		sDly_d       = sDly_q;
		sSdaLow_d    = sSdaLow_q;
		sPend_d      = sPend_q;
		sRead_d      = sRead_q;
		sNack_d      = sNack_q;
		ownAddr_d    = ownAddr_q;
		locked_d     = locked_q;
		slvRxData_d  = slvRxData;
		slvTxTake_d  = 1'b0;
		slvAddrHit_d = 1'b0;
		slvRxValid_d = 1'b0;
		slvStop_d    = 1'b0;
		if (ownAddrWr && !locked_q)
		begin
			ownAddr_d = ownAddrIn;
			locked_d  = 1'b1;
		end
		// delayed sda update after scl fall
		if (sDly_q != '0)
		begin
			sDly_d = sDly_q - 1'b1;
			if (sDly_q == 1)
				sSdaLow_d = sPend_q;
		end
		// scl sampled as input in slave role
		if (sclRise && sBit_q != `I2C_ACK_IDX)
		begin
			if (sState_q == S_ADDR || sState_q == S_RX)
				sShift_d = {sShift_q[6:0], sdaS};
		end
		else if (sclRise && sState_q == S_TX)
			sNack_d = sdaS;
		if (sclFall && sState_q != S_IDLE)
		begin
			sBit_d  = (sBit_q == `I2C_ACK_IDX) ? 4'h0 : sBit_q + 4'h1;
			sDly_d  = `I2C_SLV_DLY_W'(SlvDly - 1);
			sPend_d = 1'b0;
			case (sState_q)
				S_ADDR:
					if (sBit_q == `I2C_LAST_IDX)
					begin
						if (sShift_q[7:1] == ownAddr_q)
						begin
							sPend_d      = 1'b1;
							slvAddrHit_d = 1'b1;
							sRead_d      = sShift_q[0];
						end
						else
							sState_d = S_IDLE;
					end
					else if (sBit_q == `I2C_ACK_IDX)
					begin
						if (sRead_q)
						begin
							sState_d    = S_TX;
							sShift_d    = slvTxData;
							slvTxTake_d = 1'b1;
							sPend_d     = !slvTxData[7];
						end
						else
							sState_d = S_RX;
					end
				S_RX:
					if (sBit_q == `I2C_LAST_IDX)
					begin
						sPend_d      = 1'b1;
						slvRxValid_d = 1'b1;
						slvRxData_d  = sShift_q;
					end
				default:
					if (sBit_q < `I2C_LAST_IDX)
					begin
						sShift_d = {sShift_q[6:0], 1'b0};
						sPend_d  = !sShift_q[6];
					end
					else if (sBit_q == `I2C_ACK_IDX)
					begin
						if (sNack_q)
							sState_d = S_IDLE;
						else
						begin
							sShift_d    = slvTxData;
							slvTxTake_d = 1'b1;
							sPend_d     = !slvTxData[7];
						end
					end
			endcase
		end
		if (startDet)
		begin
			sState_d  = S_ADDR;
			// the scl fall after the start moves to bit 0
			sBit_d    = `I2C_PRE_IDX;
			sDly_d    = '0;
			sSdaLow_d = 1'b0;
		end
		else if (stopDet)
		begin
			slvStop_d = (sState_q != S_IDLE);
			sState_d  = S_IDLE;
			sDly_d    = '0;
			sSdaLow_d = 1'b0;
		end
		if (masterMode)
		begin
			sState_d  = S_IDLE;
			sDly_d    = '0;
			sSdaLow_d = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			sState_q   <= S_IDLE;
			sBit_q     <= 4'h0;
			sShift_q   <= 8'h00;
			sDly_q     <= '0;
			sSdaLow_q  <= 1'b0;
			sPend_q    <= 1'b0;
			sRead_q    <= 1'b0;
			sNack_q    <= 1'b0;
			ownAddr_q  <= `I2C_OWN_ADDR_RST;
			locked_q   <= 1'b0;
			slvRxData  <= 8'h00;
			slvTxTake  <= 1'b0;
			slvAddrHit <= 1'b0;
			slvRxValid <= 1'b0;
			slvStop    <= 1'b0;
		end
		else
		begin
			sState_q   <= sState_d;
			sBit_q     <= sBit_d;
			sShift_q   <= sShift_d;
			sDly_q     <= sDly_d;
			sSdaLow_q  <= sSdaLow_d;
			sPend_q    <= sPend_d;
			sRead_q    <= sRead_d;
			sNack_q    <= sNack_d;
			ownAddr_q  <= ownAddr_d;
			locked_q   <= locked_d;
			slvRxData  <= slvRxData_d;
			slvTxTake  <= slvTxTake_d;
			slvAddrHit <= slvAddrHit_d;
			slvRxValid <= slvRxValid_d;
			slvStop    <= slvStop_d;
		end
	end

	// pin and role registers
	role_t role_d;

	always_comb
	begin
		if (masterMode)
			role_d = (mState_q == M_IDLE || mState_q == M_FREE) ? ROLE_IDLE
				: (mWrite_q ? ROLE_MTX : ROLE_MRX);
		else if (sState_q == S_TX)
			role_d = ROLE_STX;
		else if (sState_q == S_IDLE)
			role_d = ROLE_IDLE;
		else
			role_d = ROLE_SRX;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
			sclOe  <= 1'b0;
			sdaOe  <= 1'b0;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			role   <= ROLE_IDLE;
		end
		else
		begin
			sclP_q <= sclS;
			sdaP_q <= sdaS;
			sclOe  <= masterMode && mSclLow_q;
			sdaOe  <= masterMode ? mSdaLow_q : sSdaLow_q;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			role   <= role_d;
		end
	end

	// checks
	logic [11:0] stCnt_q;
	always_ff @(posedge mclk)
	begin
		if (!reset_n || mState_d != mState_q)
			stCnt_q <= 12'h000;
		else
			stCnt_q <= stCnt_q + 12'h001;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property pDwell(mst_state_t st, logic [11:0] len);
		(masterMode && mState_q == st && mState_d != st) |-> stCnt_q == len;
	endproperty
	sequence sStopSetup;
		$past(mState_q) == M_STOP_B && mState_q == M_STOP_C;
	endsequence
	sequence sStopEdge;
		mState_q == M_STOP_C && tmrDone && masterMode;
	endsequence
	sequence sAddrMatch;
		sState_q == S_ADDR && sclFall && sBit_q == `I2C_LAST_IDX
			&& sShift_q[7:1] == ownAddr_q && !startDet && !masterMode;
	endsequence

	a_scl_high:   assert property (pDwell(M_HIGH, lenHi))
		else $error("scl high phase length wrong");
	a_sda_hold:   assert property (pDwell(M_HOLD, lenHold))
		else $error("sda hold after scl fall wrong");
	a_sda_setup:  assert property (pDwell(M_SETUP, lenHold))
		else $error("sda setup before scl rise wrong");
	a_start_hold: assert property (pDwell(M_START, lenStart))
		else $error("start hold length wrong");
	a_bus_free:   assert property (pDwell(M_FREE, lenStart))
		else $error("bus free time wrong");
	a_stop_order: assert property (sStopSetup |-> !mSclLow_q && mSdaLow_q)
		else $error("stop setup not with scl high");
	a_stop_edge:  assert property (sStopEdge |=> !mSdaLow_q && !mSclLow_q)
		else $error("stop edge not with scl high");
	a_start_edge: assert property ((masterMode && mState_q == M_START
		&& $past(mState_q) != M_START) |-> mSdaLow_q && !mSclLow_q
		&& $past(mSdaLow_q) == 1'b0)
		else $error("start edge not with scl high");
	a_msb_first:  assert property ((mState_q == M_SETUP && mWrite_q
		&& $past(mState_q) == M_HOLD && mBit_q < `I2C_ACK_IDX)
		|-> mSdaLow_q == !shReg_q[7])
		else $error("master bit order wrong");
	a_read_ack:   assert property ((mState_q == M_SETUP && !mWrite_q
		&& $past(mState_q) == M_HOLD && mBit_q == `I2C_ACK_IDX)
		|-> mSdaLow_q == !nackLast_q)
		else $error("master read ack wrong");
	a_addr_ack:   assert property (sAddrMatch |-> ##[SlvDly:SlvDly] sSdaLow_q)
		else $error("slave address ack missing");
	a_addr_once:  assert property (locked_q |=> $stable(ownAddr_q))
		else $error("own address changed twice");
	a_pins_pull:  assert property (!sclOut && !sdaOut)
		else $error("pin driven high");
endmodule
`default_nettype wire

// *** i2c_bus_target.sv ***
// behavioural target device on the two-wire bus, answers one address
// assumes pull-ups on both wires and sampling on the operating clock
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_target
#(
	parameter logic [6:0] ADDR = 7'h5a,
	parameter logic [7:0] TX0  = 8'h96
)
(
	// clock
	input  wire logic       mclk,
	// bus wires
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sdaOe,
	// last byte written to it
	output logic      [7:0] rxByte
);
	logic [3:0] cnt    = 4'h0;
	logic [7:0] sh     = 8'h00;
	logic [7:0] txSh   = 8'h00;
	logic [7:0] txNext = TX0;
	logic [1:0] st     = 2'h0;
	logic       ackPh  = 1'b0;
	logic       sclP   = 1'b1;
	logic       sdaP   = 1'b1;

	initial
	begin
		sdaOe  = 1'b0;
		rxByte = 8'h00;
	end

	always @(posedge mclk)
	begin
		sclP <= scl;
		sdaP <= sda;
		// start or stop while scl high
		if (scl && sclP && sdaP != sda)
		begin
			st    <= sda ? 2'h0 : 2'h1;
			cnt   <= 4'h0;
			ackPh <= 1'b0;
			sdaOe <= 1'b0;
		end
		else if (scl && !sclP && st != 2'h0)
		begin
			if (cnt != 4'h8)
			begin
				sh  <= {sh[6:0], sda};
				cnt <= cnt + 4'h1;
			end
			else if (st == 2'h3 && sda)
				st <= 2'h0;
		end
		else if (!scl && sclP && st != 2'h0)
		begin
			if (ackPh)
			begin
				ackPh <= 1'b0;
				cnt   <= 4'h0;
				sdaOe <= st == 2'h3 && !txNext[7];
				if (st == 2'h3)
				begin
					txSh   <= txNext;
					txNext <= txNext + 8'h01;
				end
			end
			else if (cnt == 4'h8)
			begin
				ackPh <= 1'b1;
				sdaOe <= st == 2'h2 || (st == 2'h1 && sh[7:1] == ADDR);
				if (st == 2'h1)
					st <= (sh[7:1] == ADDR) ? {1'b1, sh[0]} : 2'h0;
				if (st == 2'h2)
					rxByte <= sh;
			end
			else if (st == 2'h3)
			begin
				sdaOe <= !txSh[6];
				txSh  <= {txSh[6:0], 1'b0};
			end
		end
	end
endmodule
`default_nettype wire

// *** i2c_master_slave_controller_tb.sv ***
// self-checking bench for the two-wire controller, master and slave
// assumes the target model file and the design files compiled before it
`timescale 1ns/10ps
`default_nettype none
module i2c_master_slave_controller_tb
	import i2c_pkg::*;
;
	logic mclk, reset_n, masterMode, fastMode, ownAddrWr, cmdValid;
	logic [7:0] divN, cmdData, slvTxData, rspData, slvRxData, mdlRx;
	logic [6:0] ownAddrIn;
	cmd_t cmdCode;
	role_t role;
	logic cmdReady, rspValid, rspAck, slvTxTake, slvAddrHit, slvRxValid;
	logic slvStop, sclOut, sclOe, sdaOut, sdaOe, mdlOe;
	logic tbScl, tbSda, sclP, oeP, ack;
	logic [15:0] hiCnt, perCnt, hiLen, perLen;
	logic [7:0] fallCnt, oeDly, rxLast, rdB;
	logic [3:0] hitN = 4'h0, takeN = 4'h0, stopN = 4'h0;
	int errorCnt = 0;
	int compares = 0;
	wire scl = tbScl && !sclOe;
	wire sda = tbSda && !sdaOe && !mdlOe;

	i2c_master_slave_controller i_dut (.mclk(mclk), .reset_n(reset_n),
		.masterMode(masterMode), .fastMode(fastMode), .divN(divN),
		.ownAddrIn(ownAddrIn), .ownAddrWr(ownAddrWr), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .cmdData(cmdData), .cmdReady(cmdReady),
		.rspValid(rspValid), .rspData(rspData), .rspAck(rspAck),
		.slvTxData(slvTxData), .slvTxTake(slvTxTake),
		.slvAddrHit(slvAddrHit), .slvRxValid(slvRxValid),
		.slvRxData(slvRxData), .slvStop(slvStop), .role(role),
		.sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
		.sdaOut(sdaOut), .sdaOe(sdaOe));
	i2c_bus_target i_tgt (.mclk(mclk), .scl(scl), .sda(sda),
		.sdaOe(mdlOe), .rxByte(mdlRx));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// scl phase lengths and slave output delay after scl fall
	always @(posedge mclk)
	begin
		sclP    <= scl;
		oeP     <= sdaOe;
		hiCnt   <= scl ? hiCnt + 16'h1 : 16'h0;
		perCnt  <= (scl && !sclP) ? 16'h1 : perCnt + 16'h1;
		fallCnt <= (!scl && sclP) ? 8'h1 : fallCnt + 8'h1;
		if (!scl && sclP)
			hiLen <= hiCnt;
		if (scl && !sclP)
			perLen <= perCnt;
		if (sdaOe != oeP)
			oeDly <= fallCnt;
		if (slvRxValid)
			rxLast <= slvRxData;
		if (slvAddrHit === 1'b1)
			hitN <= hitN + 4'h1;
		if (slvTxTake === 1'b1)
			takeN <= takeN + 4'h1;
		if (slvStop === 1'b1)
			stopN <= stopN + 4'h1;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tmo;
		check(16'h0, 16'h1);
		results();
	endtask

	task automatic waitReady;
		int i;
		for (i = 0; i < 20000 && cmdReady !== 1'b1; i++)
			@(negedge mclk);
		if (i == 20000)
			tmo();
	endtask

	task automatic cmd(input cmd_t c, input logic [7:0] d);
		int i;
		waitReady();
		cmdValid = 1'b1;
		cmdCode  = c;
		cmdData  = d;
		@(negedge mclk);
		cmdValid = 1'b0;
		@(negedge mclk);
		for (i = 0; i < 20000 && c != CMD_STOP && rspValid !== 1'b1; i++)
			@(negedge mclk);
		if (i == 20000)
			tmo();
	endtask

	// far master keeps period 13, high 6
	task automatic bbBit(input logic b, output logic r);
		tbSda = b;
		repeat (5) @(negedge mclk);
		tbScl = 1'b1;
		repeat (6) @(negedge mclk);
		r     = sda;
		tbScl = 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	task automatic bbByte(input logic [7:0] b, input logic ao,
		output logic [7:0] r, output logic ai);
		for (int i = 7; i >= 0; i--)
			bbBit(b[i], r[i]);
		bbBit(ao, ai);
	endtask

	task automatic bbEdge(input logic s0, input logic s1);
		tbSda = s0;
		repeat (3) @(negedge mclk);
		tbScl = 1'b1;
		repeat (6) @(negedge mclk);
		tbSda = s1;
		repeat (6) @(negedge mclk);
		tbScl = s1;
		repeat (2) @(negedge mclk);
	endtask

	task automatic scnMasterStd;
		cmd(CMD_START, 8'hb4);
		check(rspAck, 16'h1);
		check(rspData, 16'hb4);
		check(role, ROLE_MTX);
		cmd(CMD_WRITE, 8'ha5);
		check(mdlRx, 16'ha5);
		check(rspAck, 16'h1);
		check(hiLen, 16'h0008);
		check(perLen, 16'h0010);
		cmd(CMD_START, 8'hb5);
		check(rspAck, 16'h1);
		@(negedge mclk);
		check(role, ROLE_MRX);
		cmd(CMD_READ, 8'h00);
		check(rspData, 16'h96);
		cmd(CMD_READ, 8'h01);
		check(rspData, 16'h97);
		check(rspAck, 16'h0);
		check({sclOut, sdaOut}, 16'h0);
		cmd(CMD_STOP, 8'h00);
	endtask

	task automatic scnMasterFast;
		waitReady();
		fastMode = 1'b1;
		divN     = 8'hff;
		cmd(CMD_START, 8'h22);
		check(rspAck, 16'h0);
		check(hiLen, 16'h0200);
		check(perLen, 16'h0600);
		cmd(CMD_STOP, 8'h00);
	endtask

	task automatic scnAbort;
		waitReady();
		fastMode = 1'b0;
		divN     = 8'h01;
		cmdValid = 1'b1;
		cmdCode  = CMD_START;
		cmdData  = 8'hb4;
		@(negedge mclk);
		cmdValid = 1'b0;
		repeat (40) @(negedge mclk);
		reset_n    = 1'b0;
		masterMode = 1'b0;
		repeat (4) @(negedge mclk);
		check({sclOe, sdaOe, cmdReady}, 16'h0);
		check(role, ROLE_IDLE);
		reset_n = 1'b1;
		repeat (20) @(negedge mclk);
	endtask

	task automatic scnSlave;
		bbEdge(1'b1, 1'b0);
		bbByte(8'h80, 1'b1, rdB, ack);
		check(ack, 16'h0);
		check(role, ROLE_SRX);
		check(oeDly >= 8'h3 && oeDly <= 8'h5, 16'h1);
		bbByte(8'h3c, 1'b1, rdB, ack);
		check({ack, rxLast}, 16'h3c);
		bbEdge(1'b0, 1'b1);
		ownAddrIn = 7'h33;
		ownAddrWr = 1'b1;
		@(negedge mclk);
		ownAddrIn = 7'h22;
		@(negedge mclk);
		ownAddrWr = 1'b0;
		bbEdge(1'b1, 1'b0);
		bbByte(8'h44, 1'b1, rdB, ack);
		check(ack, 16'h1);
		bbEdge(1'b1, 1'b0);
		bbByte(8'h67, 1'b1, rdB, ack);
		check(ack, 16'h0);
		repeat (2) @(negedge mclk);
		check(role, ROLE_STX);
		bbByte(8'hff, 1'b0, rdB, ack);
		check(rdB, 16'hc3);
		bbByte(8'hff, 1'b1, rdB, ack);
		check(rdB, 16'hc3);
		bbEdge(1'b0, 1'b1);
		check(hitN, 16'h2);
		check(takeN, 16'h2);
		check(stopN, 16'h1);
	endtask

	initial
	begin
		reset_n    = 1'b0;
		masterMode = 1'b1;
		fastMode   = 1'b0;
		divN       = 8'h01;
		ownAddrIn  = 7'h00;
		ownAddrWr  = 1'b0;
		cmdValid   = 1'b0;
		cmdCode    = CMD_START;
		cmdData    = 8'h00;
		slvTxData  = 8'hc3;
		tbScl      = 1'b1;
		tbSda      = 1'b1;
		repeat (10) @(negedge mclk);
		check({sclOe, sdaOe, cmdReady}, 16'h0);
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		scnMasterStd();
		scnMasterFast();
		scnAbort();
		scnSlave();
		results();
	end
endmodule
`default_nettype wire
